// ---- hw/scp_device.sv ----
module scp_device
    import scp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    scp_if.dev               bus,
    input  wire logic [2:0]  mode_strap_input,
    input  wire logic [2:0]  address_strap_input,
    input  wire logic [7:0]  cp_status,
    input  wire logic [39:0] ksv_value,
    output logic             low_freq_range_mode,
    output logic             repeater_mode,
    output logic             backward_compat_mode,
    output logic             second_audio_data_input_en,
    output logic             video_18bit,
    output logic [7:0]       pclk_min_mhz,
    output logic [7:0]       pclk_max_mhz,
    output logic             pclk_max_excl,
    output logic             reencrypt_en,
    output logic             blank_aux_en,
    output logic [7:0]       gpio_en,
    output logic [7:0]       cp_control
);
    typedef struct packed {
        logic                        scl_q;
        logic                        sda_q;
        logic [1:0]                  settle;
        logic [2:0]                  mode_lvl;
        logic [2:0]                  addr_lvl;
        scp_dst_t                    st;
        logic [3:0]                  cnt;
        logic [7:0]                  sh;
        logic                        rnw;
        logic                        first;
        logic                        acked;
        logic [7:0]                  ptr;
        logic                        sda_oe;
        logic [SCP_RW_REGS-1:0][7:0] regs;
        logic [3:0]                  mode;
        logic [7:0]                  pmin;
        logic [7:0]                  pmax;
        logic                        pexcl;
        logic                        bl_en;
        logic [7:0]                  gpio;
    } scp_dev_st_t;

    scp_dev_st_t r;
    scp_dev_st_t n;

    logic       scl_s;
    logic       sda_s;
    logic [5:0] straps_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic [6:0] eff_addr;
    logic [3:0] eff_mode;
    logic [7:0] rd_val;

    scp_sync #(.W(2)) u_pin_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({bus.scl, bus.sda}),
        .q    ({scl_s, sda_s})
    );

    scp_sync #(.W(6)) u_strap_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({mode_strap_input, address_strap_input}),
        .q    (straps_s)
    );

    always_comb begin
        n        = r;
        scl_rise = scl_s & ~r.scl_q;
        scl_fall = ~scl_s & r.scl_q;
        start_c  = scl_s & r.scl_q & r.sda_q & ~sda_s;
        stop_c   = scl_s & r.scl_q & ~r.sda_q & sda_s;
        n.scl_q  = scl_s;
        n.sda_q  = sda_s;

        // straps sampled once, after the synchroniser has filled
        if (r.settle != SCP_STRAP_DONE) begin
            n.settle = r.settle + 2'h1;
            if (r.settle == SCP_STRAP_TAKE) begin
                n.mode_lvl = straps_s[5:3];
                n.addr_lvl = straps_s[2:0];
            end
        end

        if (r.regs[SCP_REG_ID[1:0]][SCP_ID_OVR_BIT]) begin
            eff_addr = r.regs[SCP_REG_ID[1:0]][7:1];
        end else begin
            eff_addr = SCP_ADDR_BASE + {3'h0, r.addr_lvl, 1'b0};
        end

        if (r.regs[SCP_REG_MODE[1:0]][SCP_MODE_OVR_BIT]) begin
            eff_mode = r.regs[SCP_REG_MODE[1:0]][4:1];
        end else begin
            eff_mode = SCP_MODE_TABLE[r.mode_lvl];
        end

        rd_val = 8'h00;
        if (r.ptr < 8'(SCP_RW_REGS)) begin
            rd_val = r.regs[r.ptr[1:0]];
        end else if (r.ptr == SCP_REG_CPSTAT) begin
            rd_val = cp_status;
        end else if (r.ptr == SCP_REG_STRAP) begin
            rd_val = {1'b0, r.addr_lvl, r.mode};
        end
        for (int i = 0; i < SCP_KSV_BYTES; i++) begin
            if (r.ptr == SCP_REG_KSV0 + 8'(i)) begin
                rd_val = ksv_value[8*i +: 8];
            end
        end

        // sda_oe only ever pulls low; high comes from the pull-up
        if (start_c) begin
            n.st     = SCP_S_ADDR;
            n.cnt    = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            n.st     = SCP_S_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (r.st)
                SCP_S_ADDR: begin
                    if (scl_rise) begin
                        n.sh  = {r.sh[6:0], sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (scl_fall && r.cnt == SCP_ACK_BIT) begin
                        if (r.sh[7:1] == eff_addr) begin
                            n.sda_oe = 1'b1;
                            n.rnw    = r.sh[0];
                            n.st     = SCP_S_AACK;
                        end else begin
                            n.st = SCP_S_IDLE;
                        end
                    end
                end
                SCP_S_AACK: begin
                    if (scl_fall) begin
                        n.cnt = 4'h0;
                        if (r.rnw) begin
                            n.sh     = rd_val;
                            n.sda_oe = ~rd_val[7];
                            n.st     = SCP_S_RBYTE;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.first  = 1'b1;
                            n.st     = SCP_S_WBYTE;
                        end
                    end
                end
                SCP_S_WBYTE: begin
                    if (scl_rise) begin
                        n.sh  = {r.sh[6:0], sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (scl_fall && r.cnt == SCP_ACK_BIT) begin
                        if (r.first) begin
                            n.ptr   = r.sh;
                            n.first = 1'b0;
                        end else begin
                            if (r.ptr < 8'(SCP_RW_REGS)) begin
                                n.regs[r.ptr[1:0]] = r.sh;
                            end
                            n.ptr = r.ptr + 8'h01;
                        end
                        n.sda_oe = 1'b1;
                        n.st     = SCP_S_WACK;
                    end
                end
                SCP_S_WACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.cnt    = 4'h0;
                        n.st     = SCP_S_WBYTE;
                    end
                end
                SCP_S_RBYTE: begin
                    if (scl_fall) begin
                        if (r.cnt == 4'h7) begin
                            n.sda_oe = 1'b0;
                            n.st     = SCP_S_RACK;
                        end else begin
                            n.cnt    = r.cnt + 4'h1;
                            n.sh     = {r.sh[6:0], 1'b0};
                            n.sda_oe = ~r.sh[6];
                        end
                    end
                end
                SCP_S_RACK: begin
                    if (scl_rise) begin
                        n.acked = ~sda_s;
                        if (!sda_s) begin
                            n.ptr = r.ptr + 8'h01;
                        end
                    end
                    if (scl_fall) begin
                        n.cnt = 4'h0;
                        if (r.acked) begin
                            n.sh     = rd_val;
                            n.sda_oe = ~rd_val[7];
                            n.st     = SCP_S_RBYTE;
                        end else begin
                            n.st = SCP_S_IDLE;
                        end
                    end
                end
                SCP_S_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                default: begin
                    n.st     = SCP_S_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end

        n.mode  = eff_mode;
        n.bl_en = 1'b1;
        if (eff_mode[SCP_MB_LF]) begin
            n.pmin  = SCP_PCLK_LF_MIN_MHZ;
            n.pmax  = SCP_PCLK_LF_LIM_MHZ;
            n.pexcl = 1'b1;
        end else begin
            n.pmin  = SCP_PCLK_MIN_MHZ;
            n.pmax  = eff_mode[SCP_MB_BC] ? SCP_PCLK_MAX_BC_MHZ : SCP_PCLK_MAX_MHZ;
            n.pexcl = 1'b0;
        end
        // freed pixel inputs only become gpio in 18-bit mode
        n.gpio = eff_mode[SCP_MB_CHB] ? r.regs[SCP_REG_GPIO[1:0]] : 8'h00;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r        <= '0;
            r.scl_q  <= 1'b1;
            r.sda_q  <= 1'b1;
            r.st     <= SCP_S_IDLE;
            r.regs   <= {SCP_RW_REGS{SCP_REG_RST}};
            r.pmin   <= SCP_PCLK_MIN_MHZ;
            r.pmax   <= SCP_PCLK_MAX_MHZ;
        end else begin
            r <= n;
        end
    end

    assign bus.sda_dev_oe             = r.sda_oe;
    assign low_freq_range_mode        = r.mode[SCP_MB_LF];
    assign repeater_mode              = r.mode[SCP_MB_REP];
    assign backward_compat_mode       = r.mode[SCP_MB_BC];
    assign second_audio_data_input_en = r.mode[SCP_MB_CHB];
    assign video_18bit                = r.mode[SCP_MB_CHB];
    assign pclk_min_mhz               = r.pmin;
    assign pclk_max_mhz               = r.pmax;
    assign pclk_max_excl              = r.pexcl;
    assign reencrypt_en               = r.mode[SCP_MB_REP];
    assign blank_aux_en               = r.bl_en;
    assign gpio_en                    = r.gpio;
    assign cp_control                 = r.regs[SCP_REG_CPCTL[1:0]];
endmodule : scp_device

// ---- inc/scp_pkg.sv ----
package scp_pkg;
    localparam int          SCP_CLK_NS          = 50;
    // quarter of the generated bus clock period
    localparam int          SCP_SCL_QUARTER_NS  = 250;
    localparam int          SCP_SCL_QUARTER_CYC = (SCP_SCL_QUARTER_NS + SCP_CLK_NS - 1) / SCP_CLK_NS;
    localparam logic [2:0]  SCP_DIV_LAST        = 3'(SCP_SCL_QUARTER_CYC - 1);

    localparam logic [6:0]  SCP_ADDR_BASE       = 7'h0c;
    localparam logic [1:0]  SCP_STRAP_TAKE      = 2'h2;
    localparam logic [1:0]  SCP_STRAP_DONE      = 2'h3;

    // mode word {low_freq, repeater, backward_compat, second_audio}, index = strap level
    localparam int          SCP_MB_LF           = 3;
    localparam int          SCP_MB_REP          = 2;
    localparam int          SCP_MB_BC           = 1;
    localparam int          SCP_MB_CHB          = 0;
    localparam logic [7:0][3:0] SCP_MODE_TABLE  = {4'ha, 4'hd, 4'hc, 4'h9, 4'h8, 4'h5, 4'h4, 4'h0};

    localparam logic [7:0]  SCP_PCLK_MIN_MHZ    = 8'h0f;
    localparam logic [7:0]  SCP_PCLK_MAX_MHZ    = 8'h55;
    localparam logic [7:0]  SCP_PCLK_MAX_BC_MHZ = 8'h41;
    localparam logic [7:0]  SCP_PCLK_LF_MIN_MHZ = 8'h05;
    localparam logic [7:0]  SCP_PCLK_LF_LIM_MHZ = 8'h0f;

    localparam int          SCP_RW_REGS         = 4;
    localparam int          SCP_KSV_BYTES       = 5;
    localparam logic [7:0]  SCP_REG_ID          = 8'h00;
    localparam logic [7:0]  SCP_REG_MODE        = 8'h01;
    localparam logic [7:0]  SCP_REG_CPCTL       = 8'h02;
    localparam logic [7:0]  SCP_REG_GPIO        = 8'h03;
    localparam logic [7:0]  SCP_REG_CPSTAT      = 8'h04;
    localparam logic [7:0]  SCP_REG_STRAP       = 8'h05;
    localparam logic [7:0]  SCP_REG_KSV0        = 8'h06;
    localparam logic [7:0]  SCP_REG_RST         = 8'h00;
    localparam int          SCP_ID_OVR_BIT      = 0;
    localparam int          SCP_MODE_OVR_BIT    = 0;

    localparam logic [3:0]  SCP_AV_CMD          = 4'h0;
    localparam logic [3:0]  SCP_AV_STAT         = 4'h4;

    localparam logic [2:0]  SCP_STEP_WADDR      = 3'h1;
    localparam logic [2:0]  SCP_STEP_OFF        = 3'h2;
    localparam logic [2:0]  SCP_STEP_WDAT       = 3'h3;
    localparam logic [2:0]  SCP_STEP_RESTART    = 3'h3;
    localparam logic [2:0]  SCP_STEP_RADDR      = 3'h4;
    localparam logic [2:0]  SCP_STEP_WSTOP      = 3'h4;
    localparam logic [2:0]  SCP_STEP_RECV       = 3'h5;
    localparam logic [2:0]  SCP_STEP_RSTOP      = 3'h6;
    localparam logic [3:0]  SCP_ACK_BIT         = 4'h8;

    typedef enum logic [2:0] {
        SCP_S_IDLE  = 3'b000,
        SCP_S_ADDR  = 3'b001,
        SCP_S_AACK  = 3'b010,
        SCP_S_WBYTE = 3'b011,
        SCP_S_WACK  = 3'b100,
        SCP_S_RBYTE = 3'b101,
        SCP_S_RACK  = 3'b110
    } scp_dst_t;

    typedef enum logic [1:0] {
        SCP_H_IDLE  = 2'b00,
        SCP_H_START = 2'b01,
        SCP_H_BYTE  = 2'b10,
        SCP_H_STOP  = 2'b11
    } scp_hst_t;
endpackage : scp_pkg

// ---- inc/scp_if.sv ----
interface scp_if;
    logic sda_dev_oe;
    logic scl_host_oe;
    logic sda_host_oe;
    logic scl;
    logic sda;

    // open-drain wires: low while any party pulls, else pulled up
    assign scl = ~scl_host_oe;
    assign sda = ~(sda_dev_oe | sda_host_oe);

    modport dev  (input scl, input sda, output sda_dev_oe);
    modport host (input scl, input sda, output scl_host_oe, output sda_host_oe);
endinterface : scp_if

// ---- hw/scp_sync.sv ----
module scp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } scp_sync_st_t;

    scp_sync_st_t r;
    scp_sync_st_t n;

    always_comb begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.s2;
endmodule : scp_sync

// ---- hw/scp_host.sv ----
module scp_host
    import scp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    scp_if.host              bus,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    typedef struct packed {
        scp_hst_t    st;
        logic [1:0]  ph;
        logic [2:0]  div;
        logic [3:0]  bitn;
        logic [2:0]  step;
        logic [7:0]  txb;
        logic [7:0]  rxb;
        logic [7:0]  rdat;
        logic [6:0]  addr;
        logic        rnw;
        logic [7:0]  off;
        logic [7:0]  wdat;
        logic        nack;
        logic        busy;
        logic        nak_seen;
        logic        scl_oe;
        logic        sda_oe;
        logic        wreq;
        logic [31:0] rd;
    } scp_host_st_t;

    scp_host_st_t r;
    scp_host_st_t n;

    logic sda_s;
    logic tick;
    logic recv;
    logic hit_cmd;
    logic hit_stat;

    function automatic scp_hst_t item_of(input logic [2:0] s, input logic rd);
        if (s == 3'h0 || (rd && s == SCP_STEP_RESTART)) begin
            return SCP_H_START;
        end
        if ((!rd && s == SCP_STEP_WSTOP) || (rd && s == SCP_STEP_RSTOP)) begin
            return SCP_H_STOP;
        end
        return SCP_H_BYTE;
    endfunction : item_of

    function automatic logic [7:0] byte_of(input logic [2:0] s, input logic rd,
                                           input logic [6:0] a, input logic [7:0] o,
                                           input logic [7:0] w);
        if (s == SCP_STEP_WADDR) begin
            return {a, 1'b0};
        end
        if (s == SCP_STEP_OFF) begin
            return o;
        end
        if (!rd && s == SCP_STEP_WDAT) begin
            return w;
        end
        if (rd && s == SCP_STEP_RADDR) begin
            return {a, 1'b1};
        end
        return 8'hff;
    endfunction : byte_of

    scp_sync #(.W(1)) u_sda_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (bus.sda),
        .q    (sda_s)
    );

    always_comb begin
        n        = r;
        hit_cmd  = (avs_address == SCP_AV_CMD);
        hit_stat = (avs_address == SCP_AV_STAT);
        tick     = (r.div == SCP_DIV_LAST);
        recv     = r.rnw && (r.step == SCP_STEP_RECV);

        // one wait cycle per access; a command write stalls while busy
        if (!r.wreq) begin
            n.wreq = 1'b1;
        end else if ((avs_read || avs_write) && !(avs_write && hit_cmd && r.busy)) begin
            n.wreq = 1'b0;
            n.rd   = (avs_read && hit_stat) ?
                     {16'h0000, r.rdat, 6'h00, r.nack, r.busy} : 32'h0000_0000;
        end

        if (!r.wreq && avs_write && hit_cmd) begin
            if (avs_byteenable[0]) begin
                n.addr = avs_writedata[6:0];
                n.rnw  = avs_writedata[7];
            end
            if (avs_byteenable[1]) begin
                n.off = avs_writedata[15:8];
            end
            if (avs_byteenable[2]) begin
                n.wdat = avs_writedata[23:16];
            end
            n.busy   = 1'b1;
            n.nack   = 1'b0;
            n.st     = SCP_H_START;
            n.ph     = 2'h0;
            n.step   = 3'h0;
            n.div    = 3'h0;
            n.sda_oe = 1'b0;
        end else if (r.busy) begin
            n.div = tick ? 3'h0 : r.div + 3'h1;
            if (tick) begin
                if (r.ph != 2'h3) begin
                    n.ph = r.ph + 2'h1;
                end else if (r.st == SCP_H_BYTE && r.bitn != SCP_ACK_BIT) begin
                    n.bitn = r.bitn + 4'h1;
                    n.ph   = 2'h0;
                    n.txb  = {r.txb[6:0], 1'b1};
                end else if (r.st == SCP_H_STOP) begin
                    n.st   = SCP_H_IDLE;
                    n.busy = 1'b0;
                    n.ph   = 2'h0;
                end else begin
                    if (r.st == SCP_H_BYTE && recv) begin
                        n.rdat = r.rxb;
                    end
                    if (r.st == SCP_H_BYTE && r.nak_seen) begin
                        n.st   = SCP_H_STOP;
                        n.nack = 1'b1;
                    end else begin
                        n.step = r.step + 3'h1;
                        n.st   = item_of(n.step, r.rnw);
                        n.txb  = byte_of(n.step, r.rnw, r.addr, r.off, r.wdat);
                    end
                    n.bitn = 4'h0;
                    n.ph   = 2'h0;
                end

                case (n.st)
                    SCP_H_START: begin
                        case (n.ph)
                            2'h0: n.sda_oe = 1'b0;
                            2'h1: n.scl_oe = 1'b0;
                            2'h2: n.sda_oe = 1'b1;
                            default: n.scl_oe = 1'b1;
                        endcase
                    end
                    SCP_H_BYTE: begin
                        case (n.ph)
                            2'h0: n.sda_oe = (!recv && n.bitn != SCP_ACK_BIT) ? ~n.txb[7] : 1'b0;
                            2'h1: n.scl_oe = 1'b0;
                            2'h2: begin
                                if (r.bitn != SCP_ACK_BIT) begin
                                    n.rxb = {r.rxb[6:0], sda_s};
                                end else begin
                                    n.nak_seen = sda_s & ~recv;
                                end
                            end
                            default: n.scl_oe = 1'b1;
                        endcase
                    end
                    SCP_H_STOP: begin
                        case (n.ph)
                            2'h0: n.sda_oe = 1'b1;
                            2'h1: n.scl_oe = 1'b0;
                            2'h2: n.sda_oe = 1'b0;
                            default: n.sda_oe = 1'b0;
                        endcase
                    end
                    default: begin
                        n.scl_oe = 1'b0;
                        n.sda_oe = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r      <= '0;
            r.st   <= SCP_H_IDLE;
            r.wreq <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign bus.scl_host_oe = r.scl_oe;
    assign bus.sda_host_oe = r.sda_oe;
    assign avs_readdata    = r.rd;
    assign avs_waitrequest = r.wreq;
endmodule : scp_host

// ---- test/scp_bus_assertions.sv ----
module scp_bus_check (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_oe,
    input wire logic scl_host_oe,
    input wire logic sda_host_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    odrain_sda_a: assert property (sda_dev_oe || sda_host_oe |-> !sda)
        else $error("data line high while pulled");
    dev_edge_a: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl))
        else $error("device moved data while clock high");
    scl_high_a: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high phase too short");
    scl_low_a: assert property ($rose(scl_host_oe) |-> !scl[*8])
        else $error("clock low phase too short");
    start_hold_a: assert property (scl && $fell(sda) |-> ##[4:6] $fell(scl))
        else $error("start not followed by clock low");
    stop_idle_a: assert property (scl && $rose(sda) |=> scl[*8])
        else $error("clock not idle after stop");
    ack_setup_a: assert property ($rose(sda_dev_oe) |-> ##[3:8] $rose(scl))
        else $error("device pull not set before clock rise");
    ack_hold_a: assert property (sda_dev_oe && $rose(scl) |-> sda_dev_oe[*8])
        else $error("device pull dropped while clock high");
endmodule : scp_bus_check

// ---- test/scp_tb.sv ----
module scp_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  lvl = 3'h0;
    logic [7:0]  cp_status = 8'h00;
    logic [39:0] ksv_value = 40'h0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, s;
    logic        avs_waitrequest, lf, rep, bc, chb, v18, renc, excl, bl;
    logic [7:0]  pmin, pmax, cp_control, d, gp;
    logic [6:0]  a;
    logic [7:0]  exp_q[$];
    int          fail_count = 0, samples_checked = 0, seed = 50, cyc = 0;
    int          mt[8] = '{0, 4, 5, 8, 9, 12, 13, 10};
    scp_if bif();
    scp_device scp_device_inst (.clk, .nrst, .bus(bif.dev), .mode_strap_input(lvl),
        .address_strap_input(lvl), .cp_status, .ksv_value, .low_freq_range_mode(lf),
        .repeater_mode(rep), .backward_compat_mode(bc), .second_audio_data_input_en(chb),
        .video_18bit(v18), .pclk_min_mhz(pmin), .pclk_max_mhz(pmax), .pclk_max_excl(excl),
        .reencrypt_en(renc), .blank_aux_en(bl), .gpio_en(gp), .cp_control);
    scp_host scp_host_inst (.clk, .nrst, .bus(bif.host), .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest);
    scp_bus_check scp_bus_check_inst (.clk, .nrst, .scl(bif.scl), .sda(bif.sda),
        .sda_dev_oe(bif.sda_dev_oe), .scl_host_oe(bif.scl_host_oe),
        .sda_host_oe(bif.sda_host_oe));
    always #25 clk = ~clk;
    // roughly twice the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            stop_test();
        end
    end
    task stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] e);
        samples_checked++;
        if (got !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, e);
        end
    endtask : chk
    task av(input logic w, input logic [3:0] ad, input logic [31:0] wd);
        @(posedge clk);
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= ad;
        avs_writedata <= wd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        s = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av
    // waits out the bus transfer; status word is left in s
    task cmd(input logic [6:0] ad, input logic r, input logic [7:0] o, input logic [7:0] wd);
        av(1'b1, 4'h0, {8'h0, wd, o, r, ad});
        do av(1'b0, 4'h4, 32'h0); while (s[0] !== 1'b0);
    endtask : cmd
    initial begin
        ksv_value <= {8'($random(seed)), 32'($random(seed))};
        for (int i = 0; i < 8; i++) begin
            nrst <= 1'b0;
            lvl <= 3'(i);
            cp_status <= 8'($random(seed));
            repeat (12) @(posedge clk);
            nrst <= 1'b1;
            repeat (6) @(posedge clk);
            chk(32'({lf, rep, bc, chb, v18, renc}), 32'({4'(mt[i]), mt[i][0], mt[i][2]}));
            chk(32'({pmin, pmax, 7'h0, excl}), mt[i][3] ? 32'h050f01 : mt[i][1] ? 32'h0f4100 : 32'h0f5500);
            chk(32'({bl, gp}), 32'h100);
            a = 7'h0c + 7'(2 * i);
            d = 8'($random(seed));
            exp_q.push_back(d);
            cmd(a, 1'b0, 8'h02, d);
            chk(32'({s[1], cp_control}), 32'({1'b0, d}));
            cmd(a, 1'b0, 8'h03, d);
            chk(32'(gp), mt[i][0] ? 32'(d) : 32'h0);
            cmd(a + 7'h1, 1'b0, 8'h02, ~d);
            chk(32'(s[1]), 32'h1);
            cmd(a, 1'b1, 8'h02, 8'h00);
            chk(32'({s[1], s[15:8]}), 32'({1'b0, exp_q.pop_front()}));
            cmd(a, 1'b1, 8'h04, 8'h00);
            chk(32'(s[15:8]), 32'(cp_status));
            $display("level %0d test done", i);
        end
        cmd(7'h1a, 1'b0, 8'h00, 8'h41);
        cmd(7'h20, 1'b0, 8'h02, 8'h5a);
        chk(32'({s[1], cp_control}), 32'h05a);
        cmd(7'h1a, 1'b0, 8'h02, 8'h00);
        chk(32'({s[1], cp_control}), 32'h15a);
        av(1'b0, 4'h8, 32'h0);
        chk(s, 32'h0);
        cmd(7'h20, 1'b0, 8'h01, 8'h1b);
        chk(32'({lf, rep, bc, chb}), 32'hd);
        cmd(7'h20, 1'b1, 8'h05, 8'h00);
        chk(32'(s[15:8]), 32'h7d);
        for (int k = 0; k < 5; k++) begin
            cmd(7'h20, 1'b1, 8'h06 + 8'(k), 8'h00);
            chk(32'(s[15:8]), 32'(ksv_value[8*k +: 8]));
        end
        $display("override test done");
        stop_test();
    end
endmodule : scp_tb
